//--- hw/jtl_link_if.sv
// Interface joining the transmitting converter end and the receiving logic end
`timescale 1ns/1ps
`default_nettype none
interface jtl_link_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        data_valid;
  logic [7:0]  conv0;
  logic [7:0]  conv1;
  logic        frame_start;
  logic        lmfc;

  modport dev (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, data_valid, conv0, conv1, frame_start, lmfc
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_rvalid, data_valid, conv0, conv1, frame_start, lmfc
  );
endinterface
`default_nettype wire

//--- hw/jtl_pkg.sv
// Shared constants, types and helpers for the transmit link configuration block
package jtl_pkg;

  // Register map (byte addresses on the configuration port)
  localparam logic [15:0] REG_LANE_RATE   = 16'h056e;
  localparam logic [15:0] REG_LOCK_STATUS = 16'h056f;
  localparam logic [15:0] REG_QUICK_CFG   = 16'h0570;
  localparam logic [15:0] REG_MF_FRAMES   = 16'h0571;
  localparam logic [15:0] REG_LINK_PWR    = 16'h0572;

  localparam logic [7:0]  LANE_RATE_RST   = 8'h30;
  localparam logic [7:0]  QUICK_CFG_RST   = 8'h49;
  localparam logic [7:0]  MF_FRAMES_RST   = 8'h20;
  localparam logic [7:0]  LINK_PWR_RST    = 8'h00;
  localparam int          LOCK_BIT        = 7;
  localparam int          PWR_DOWN_BIT    = 0;
  localparam int          BAND_MSB        = 7;
  localparam int          BAND_LSB        = 4;

  // Lane-rate band codes for the upper nibble
  localparam logic [3:0]  BAND_HIGH       = 4'h3;
  localparam logic [3:0]  BAND_MID        = 4'h1;
  localparam logic [3:0]  BAND_LOW        = 4'h5;
  localparam logic [3:0]  BAND_NONE       = 4'hf;

  // Lane-rate thresholds in half-Mbps units so 1687.5 stays exact
  localparam int          RATE_MAX_X2     = 30000;
  localparam int          RATE_HI_X2      = 27000;
  localparam int          RATE_MID_X2     = 13500;
  localparam int          RATE_LOW_X2     = 6750;
  localparam int          RATE_MIN_X2     = 3375;
  localparam int          RATE_FACTOR_X2  = 20;

  // Multiframe length limits
  localparam int          MF_MAX          = 32;
  localparam int          MF_STEP         = 4;

  // Latency in encode clocks
  localparam int          LAT_ADC_SERDES  = 31;
  localparam int          LAT_FRM_HALF    = 23;
  localparam int          LAT_FRM_ONE     = 14;
  localparam int          LAT_FRM_TWO     = 7;

  // Synthesizer lock settle time
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          LOCK_TIME_NS    = 1000;
  localparam int          LOCK_CYCLES     = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic       valid;
    logic [1:0] lanes;
    logic [1:0] convs;
    logic [4:0] octets;
    logic [3:0] samples;
  } jtl_cfg_s;

  function automatic jtl_cfg_s jtl_decode(input logic [7:0] code);
    jtl_cfg_s c;
    c = '{valid: 1'b1, lanes: 2'd1, convs: 2'd1, octets: 5'd1, samples: 4'd1};
    case (code)
      8'h00: c = '{1'b1, 2'd1, 2'd1, 5'd1, 4'd1};
      8'h01: c = '{1'b1, 2'd1, 2'd1, 5'd2, 4'd2};
      8'h40: c = '{1'b1, 2'd2, 2'd1, 5'd1, 4'd2};
      8'h41: c = '{1'b1, 2'd2, 2'd1, 5'd2, 4'd4};
      8'h42: c = '{1'b1, 2'd2, 2'd1, 5'd4, 4'd8};
      8'h09: c = '{1'b1, 2'd1, 2'd2, 5'd2, 4'd1};
      8'h48: c = '{1'b1, 2'd2, 2'd2, 5'd1, 4'd1};
      8'h49: c = '{1'b1, 2'd2, 2'd2, 5'd2, 4'd2};
      default: c.valid = 1'b0;
    endcase
    return c;
  endfunction

  // Lane rate in half-Mbps: twenty times fout times M over L
  function automatic logic [31:0] jtl_rate_x2(input logic [10:0] fout_mhz, input jtl_cfg_s c);
    logic [31:0] num;
    num = 32'(RATE_FACTOR_X2) * 32'(fout_mhz) * 32'(c.convs);
    return (c.lanes == 2'd2) ? (num >> 1) : num;
  endfunction

  // Band 6.75..13.5 shares the top code with the highest band
  function automatic logic [3:0] jtl_band(input logic [31:0] r);
    if (r > 32'(RATE_MAX_X2) || r < 32'(RATE_MIN_X2)) return BAND_NONE;
    else if (r > 32'(RATE_MID_X2)) return BAND_HIGH;
    else if (r > 32'(RATE_LOW_X2)) return BAND_MID;
    else return BAND_LOW;
  endfunction

  function automatic logic jtl_mf_ok(input logic [7:0] k, input logic [4:0] f);
    logic [7:0] kmin;
    kmin = (f == 5'd1) ? 8'd20 : (f == 5'd2) ? 8'd12 : (f == 5'd4) ? 8'd8 : 8'd4;
    return (k[1:0] == 2'b00) && (k <= 8'(MF_MAX)) && (k >= kmin);
  endfunction

  function automatic logic [5:0] jtl_frm_lat(input jtl_cfg_s c);
    if (c.convs < c.lanes) return 6'(LAT_FRM_HALF);
    else if (c.convs == c.lanes) return 6'(LAT_FRM_ONE);
    else return 6'(LAT_FRM_TWO);
  endfunction

endpackage

//--- hw/jtl_rx_host.sv
// Receiving logic end: configuration sequencer and sample capture
`timescale 1ns/1ps
`default_nettype none
module jtl_rx_host (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  jtl_link_if.host         link,
  input  wire logic        start_in,
  input  wire logic [7:0]  qcfg_in,
  input  wire logic [7:0]  mf_frames_in,
  input  wire logic [10:0] fout_mhz_in,
  output logic             busy_out,
  output logic             ready_out,
  output logic             cfg_err_out,
  output logic             samp_valid_out,
  output logic [7:0]       samp0_out,
  output logic [7:0]       samp1_out,
  output logic             lmfc_out,
  output logic [5:0]       lat_in2lmfc_out,
  output logic [5:0]       lat_lmfc2out_out
);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_WR    = 6'b000010,
    ST_RD    = 6'b000100,
    ST_RWAIT = 6'b001000,
    ST_RUN   = 6'b010000,
    ST_ERR   = 6'b100000
  } jtl_hst_e;

  jtl_hst_e          st_ff;
  logic [2:0]        step_ff;
  logic [7:0]        qcfg_ff;
  logic [7:0]        mf_ff;
  logic [3:0]        band_ff;
  jtl_pkg::jtl_cfg_s cfg_new;
  logic [3:0]        band_new;
  logic              wr_ff;
  logic              rd_ff;
  logic [15:0]       addr_ff;
  logic [7:0]        wdata_ff;
  logic              sv_ff;
  logic [7:0]        s0_ff;
  logic [7:0]        s1_ff;
  logic              lmfc_ff;
  logic [5:0]        frm_lat_ff;

  assign cfg_new  = jtl_pkg::jtl_decode(qcfg_in);
  assign band_new = jtl_pkg::jtl_band(jtl_pkg::jtl_rate_x2(fout_mhz_in, cfg_new));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff      <= ST_IDLE;
      step_ff    <= 3'd0;
      qcfg_ff    <= 8'h00;
      mf_ff      <= 8'h00;
      band_ff    <= 4'h0;
      frm_lat_ff <= 6'd0;
      wr_ff      <= 1'b0;
      rd_ff      <= 1'b0;
      addr_ff    <= 16'h0000;
      wdata_ff   <= 8'h00;
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      case (st_ff)
        ST_IDLE, ST_RUN, ST_ERR: begin
          if (start_in) begin
            // Out-of-range rate or bad multiframe never reaches the device
            if (!cfg_new.valid || band_new == jtl_pkg::BAND_NONE
                || !jtl_pkg::jtl_mf_ok(mf_frames_in, cfg_new.octets)) begin
              st_ff <= ST_ERR;
            end else begin
              qcfg_ff    <= qcfg_in;
              mf_ff      <= mf_frames_in;
              band_ff    <= band_new;
              frm_lat_ff <= jtl_pkg::jtl_frm_lat(cfg_new);
              step_ff    <= 3'd0;
              st_ff      <= ST_WR;
            end
          end
        end
        ST_WR: begin
          wr_ff <= 1'b1;
          case (step_ff)
            3'd0: begin
              addr_ff  <= jtl_pkg::REG_LINK_PWR;
              wdata_ff <= 8'h01;
            end
            3'd1: begin
              addr_ff  <= jtl_pkg::REG_QUICK_CFG;
              wdata_ff <= qcfg_ff;
            end
            3'd2: begin
              addr_ff  <= jtl_pkg::REG_MF_FRAMES;
              wdata_ff <= mf_ff;
            end
            3'd3: begin
              addr_ff  <= jtl_pkg::REG_LANE_RATE;
              wdata_ff <= {band_ff, 4'h0};
            end
            default: begin
              addr_ff  <= jtl_pkg::REG_LINK_PWR;
              wdata_ff <= 8'h00;
            end
          endcase
          step_ff <= step_ff + 3'd1;
          if (step_ff == 3'd4) begin
            st_ff <= ST_RD;
          end
        end
        ST_RD: begin
          rd_ff   <= 1'b1;
          addr_ff <= jtl_pkg::REG_LOCK_STATUS;
          st_ff   <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if (link.reg_rvalid) begin
            st_ff <= link.reg_rdata[jtl_pkg::LOCK_BIT] ? ST_RUN : ST_RD;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Samples are captured only once the link reported lock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sv_ff   <= 1'b0;
      s0_ff   <= 8'h00;
      s1_ff   <= 8'h00;
      lmfc_ff <= 1'b0;
    end else begin
      sv_ff   <= link.data_valid && st_ff == ST_RUN;
      s0_ff   <= link.conv0;
      s1_ff   <= link.conv1;
      lmfc_ff <= link.lmfc;
    end
  end

  assign link.reg_wr    = wr_ff;
  assign link.reg_rd    = rd_ff;
  assign link.reg_addr  = addr_ff;
  assign link.reg_wdata = wdata_ff;
  assign busy_out         = (st_ff == ST_WR) || (st_ff == ST_RD) || (st_ff == ST_RWAIT);
  assign ready_out        = (st_ff == ST_RUN);
  assign cfg_err_out      = (st_ff == ST_ERR);
  assign samp_valid_out   = sv_ff;
  assign samp0_out        = s0_ff;
  assign samp1_out        = s1_ff;
  assign lmfc_out         = lmfc_ff;
  assign lat_in2lmfc_out  = 6'(jtl_pkg::LAT_ADC_SERDES);
  assign lat_lmfc2out_out = frm_lat_ff;

endmodule // jtl_rx_host
`default_nettype wire

//--- hw/jtl_tx_dev.sv
// Converter end: link configuration registers, synthesizer lock and fixed-latency output
//
// Contract
// - One-converter quick codes decode to L, F, S
// - Two-converter quick codes decode to L, F, S
// - Lane rate is ten fout times M over L
// - Lane rate must lie 1687.5 to 15000 Mbps
// - Above 6.75 Gbps band nibble is 0x3
// - Mid band nibble 0x1, lowest band 0x5
// - Multiframe length multiple of four, bounded by F
// - Converter plus serializer adds 31 clocks
// - Framing adds 23, 14 or 7 by M/L
// - Total latency is the sum, deterministic
// - Receiver may split latency at multiframe clock
// - Above 3.375 up to 6.75 Gbps write 0x10 to rate register
// - Power down, configure, then power up
// - Read-only synthesizer lock flag at bit 7
`timescale 1ns/1ps
`default_nettype none
module jtl_tx_dev #(
  parameter int LOCK_CNT = jtl_pkg::LOCK_CYCLES,
  parameter int DLY_MAX  = 64
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  jtl_link_if.dev          link,
  input  wire logic [10:0] fout_mhz_in,
  input  wire logic        samp_valid_in,
  input  wire logic [7:0]  samp0_in,
  input  wire logic [7:0]  samp1_in,
  output logic             locked_out,
  output logic [5:0]       latency_out
);

  logic [7:0]         lane_rate_ff;
  logic [7:0]         quick_cfg_ff;
  logic [7:0]         mf_frames_ff;
  logic [7:0]         link_pwr_ff;
  logic               cfg_wr;
  logic               lock_ff;
  logic [31:0]        lock_cnt_ff;
  logic               cfg_ok;
  jtl_pkg::jtl_cfg_s  cfg;
  logic [31:0]        rate_x2;
  logic [5:0]         lat;
  logic [16:0]        pipe_ff [DLY_MAX];
  logic [16:0]        tap;
  logic [7:0]         frm_cnt_ff;
  logic [7:0]         mf_cnt_ff;
  logic [7:0]         rdata_ff;
  logic               rvalid_ff;
  logic               dv_ff;
  logic [7:0]         c0_ff;
  logic [7:0]         c1_ff;
  logic               fs_ff;
  logic               lmfc_ff;
  logic               lock_done;
  logic [3:0]         band_want;
  logic [3:0]         band_set;
  logic               band_ok;
  logic               mf_ok;
  logic               pwr_up;
  logic               samp_ok;
  logic [7:0]         samp1_sel;
  logic               frm_last;
  logic               mf_last;

  assign cfg     = jtl_pkg::jtl_decode(quick_cfg_ff);
  assign rate_x2 = jtl_pkg::jtl_rate_x2(fout_mhz_in, cfg);
  assign lat     = 6'(jtl_pkg::LAT_ADC_SERDES) + jtl_pkg::jtl_frm_lat(cfg);

  // Band code the rate calls for, against the one software wrote
  assign band_want = jtl_pkg::jtl_band(rate_x2);
  assign band_set  = lane_rate_ff[jtl_pkg::BAND_MSB:jtl_pkg::BAND_LSB];
  assign band_ok   = (band_want != jtl_pkg::BAND_NONE) && (band_set == band_want);
  assign mf_ok     = jtl_pkg::jtl_mf_ok(mf_frames_ff, cfg.octets);
  assign pwr_up    = !link_pwr_ff[jtl_pkg::PWR_DOWN_BIT];

  // Synthesizer only settles when the band nibble matches the real rate
  assign cfg_ok = cfg.valid && band_ok && mf_ok && pwr_up;

  // Lock status is read-only, so it never counts as a configuration write
  function automatic logic is_cfg_addr(input logic [15:0] a);
    return (a == jtl_pkg::REG_LANE_RATE) || (a == jtl_pkg::REG_QUICK_CFG)
           || (a == jtl_pkg::REG_MF_FRAMES) || (a == jtl_pkg::REG_LINK_PWR);
  endfunction

  assign cfg_wr    = link.reg_wr && is_cfg_addr(link.reg_addr);
  assign lock_done = lock_cnt_ff >= 32'(LOCK_CNT - 1);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lane_rate_ff <= jtl_pkg::LANE_RATE_RST;
      quick_cfg_ff <= jtl_pkg::QUICK_CFG_RST;
      mf_frames_ff <= jtl_pkg::MF_FRAMES_RST;
      link_pwr_ff  <= jtl_pkg::LINK_PWR_RST;
    end else if (link.reg_wr) begin
      case (link.reg_addr)
        jtl_pkg::REG_LANE_RATE: lane_rate_ff <= link.reg_wdata;
        jtl_pkg::REG_QUICK_CFG: quick_cfg_ff <= link.reg_wdata;
        jtl_pkg::REG_MF_FRAMES: mf_frames_ff <= link.reg_wdata;
        jtl_pkg::REG_LINK_PWR:  link_pwr_ff  <= link.reg_wdata;
        default: ;
      endcase
    end
  end

  // Any configuration write restarts the settle time
  always_ff @(posedge mclk_in) begin
    if (rst_in || cfg_wr || !cfg_ok) begin
      lock_cnt_ff <= '0;
    end else if (!lock_done) begin
      lock_cnt_ff <= lock_cnt_ff + 32'd1;
    end
  end

  // Lock drops one cycle after the write that disturbs it
  always_ff @(posedge mclk_in) begin
    if (rst_in || cfg_wr || !cfg_ok) begin
      lock_ff <= 1'b0;
    end else if (lock_done) begin
      lock_ff <= 1'b1;
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= link.reg_rd;
      if (link.reg_rd) begin
        case (link.reg_addr)
          jtl_pkg::REG_LANE_RATE:   rdata_ff <= lane_rate_ff;
          jtl_pkg::REG_LOCK_STATUS: rdata_ff <= {lock_ff, 7'h00};
          jtl_pkg::REG_QUICK_CFG:   rdata_ff <= quick_cfg_ff;
          jtl_pkg::REG_MF_FRAMES:   rdata_ff <= mf_frames_ff;
          jtl_pkg::REG_LINK_PWR:    rdata_ff <= link_pwr_ff;
          default:                  rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // Samples taken while unlocked enter the line as empty slots
  assign samp_ok   = samp_valid_in && lock_ff;
  assign samp1_sel = (cfg.convs == 2'd2) ? samp1_in : 8'h00;

  // Fixed-depth delay line; tap picks the mode's latency
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      for (int i = 0; i < DLY_MAX; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[0] <= {samp_ok, samp0_in, samp1_sel};
      for (int i = 1; i < DLY_MAX; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  assign tap = pipe_ff[lat - 6'd2];

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      dv_ff <= 1'b0;
      c0_ff <= 8'h00;
      c1_ff <= 8'h00;
    end else begin
      dv_ff <= tap[16] && lock_ff;
      c0_ff <= tap[15:8];
      c1_ff <= tap[7:0];
    end
  end

  assign frm_last = (frm_cnt_ff == 8'(cfg.samples) - 8'h01);
  assign mf_last  = (mf_cnt_ff == mf_frames_ff - 8'h01);

  // Frame every S clocks, multiframe every K frames
  always_ff @(posedge mclk_in) begin
    if (rst_in || !lock_ff) begin
      frm_cnt_ff <= 8'h00;
      mf_cnt_ff  <= 8'h00;
      fs_ff      <= 1'b0;
      lmfc_ff    <= 1'b0;
    end else begin
      fs_ff   <= (frm_cnt_ff == 8'h00);
      lmfc_ff <= (frm_cnt_ff == 8'h00) && (mf_cnt_ff == 8'h00);
      if (frm_last) begin
        frm_cnt_ff <= 8'h00;
        mf_cnt_ff  <= mf_last ? 8'h00 : mf_cnt_ff + 8'h01;
      end else begin
        frm_cnt_ff <= frm_cnt_ff + 8'h01;
      end
    end
  end

  assign link.reg_rdata   = rdata_ff;
  assign link.reg_rvalid  = rvalid_ff;
  assign link.data_valid  = dv_ff;
  assign link.conv0       = c0_ff;
  assign link.conv1       = c1_ff;
  assign link.frame_start = fs_ff;
  assign link.lmfc        = lmfc_ff;
  assign locked_out       = lock_ff;
  assign latency_out      = lat;

endmodule // jtl_tx_dev
`default_nettype wire

//--- tb/jtl_link_assertions.sv
// Concurrent checks on the signals joining the two link ends
`timescale 1ns/1ps
`default_nettype none
module jtl_link_assertions (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        data_valid,
  input wire logic [7:0]  conv0,
  input wire logic [7:0]  conv1,
  input wire logic        frame_start,
  input wire logic        lmfc
);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] qcfg_ff;
  logic [3:0] gap_ff;
  logic [3:0] s_val;
  logic       cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == jtl_pkg::REG_QUICK_CFG;
  always_comb begin
    case (qcfg_ff)
      8'h01, 8'h40, 8'h49: s_val = 4'h2;
      8'h41:               s_val = 4'h4;
      8'h42:               s_val = 4'h8;
      default:             s_val = 4'h1;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) qcfg_ff <= jtl_pkg::QUICK_CFG_RST;
    else if (cfg_wr) qcfg_ff <= reg_wdata;
  end
  // Saturates so the first frame after a relock is never judged
  always_ff @(posedge mclk_in) begin
    if (rst_in) gap_ff <= 4'hf;
    else if (frame_start) gap_ff <= 4'h1;
    else if (gap_ff != 4'hf) gap_ff <= gap_ff + 4'h1;
  end
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  a_lock_bit_only: assert property (
    reg_rd && reg_addr == jtl_pkg::REG_LOCK_STATUS |=> reg_rdata[6:0] == 7'h00)
    else $error("lock status low bits not zero");
  a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_cfg_write_unlock: assert property (
    cfg_wr |-> ##2 (!frame_start && !data_valid) [*6])
    else $error("link kept running after reconfiguration");
  a_lmfc_on_frame: assert property (lmfc |-> frame_start)
    else $error("multiframe pulse off a frame boundary");
  a_conv1_single: assert property (
    data_valid && !qcfg_ff[3] |-> conv1 == 8'h00)
    else $error("second converter not zero with one converter");
  a_frame_period: assert property (
    frame_start && gap_ff <= 4'h8 |-> gap_ff == s_val)
    else $error("frame spacing differs from samples per frame");
  c_cfg_write: cover property (cfg_wr);
  c_multiframe: cover property (lmfc);
  c_two_conv_data: cover property (data_valid && qcfg_ff[3]);
  c_conv0_data: cover property (data_valid && conv0 != 8'h00);
endmodule // jtl_link_assertions
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench: both link ends joined, configured and timed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [7:0]  q;
    logic [7:0]  k;
    logic [10:0] f;
    logic        err;
    logic [3:0]  band;
    logic [5:0]  frm;
    logic [3:0]  s;
  } jtl_row_s;
  localparam int NROW = 19;
  logic        mclk_in;
  logic        rst_in;
  logic        start;
  logic [7:0]  qcfg;
  logic [7:0]  mf;
  logic [10:0] fout;
  logic        sv;
  logic [7:0]  s0;
  logic [7:0]  s1;
  logic        busy;
  logic        ready;
  logic        cfg_err;
  logic        hsv;
  logic [7:0]  h0;
  logic [7:0]  h1;
  logic        hlmfc;
  logic [5:0]  lat_a;
  logic [5:0]  lat_b;
  logic        locked;
  logic [5:0]  lat_tot;
  logic [7:0]  rate_seen;
  logic        seen;
  int          fail_count;
  int          samples_checked;
  // Rate rows sit on band edges; error rows break range, K or code
  jtl_row_s rows [NROW] = '{
    '{8'h00, 8'h14, 11'h3e8, 1'b0, 4'h3, 6'h0e, 4'h1},
    '{8'h01, 8'h0c, 11'h1f4, 1'b0, 4'h1, 6'h0e, 4'h2},
    '{8'h40, 8'h14, 11'h3e8, 1'b0, 4'h1, 6'h17, 4'h2},
    '{8'h41, 8'h0c, 11'h3e8, 1'b0, 4'h1, 6'h17, 4'h4},
    '{8'h42, 8'h08, 11'h3e8, 1'b0, 4'h1, 6'h17, 4'h8},
    '{8'h09, 8'h0c, 11'h1f4, 1'b0, 4'h3, 6'h07, 4'h1},
    '{8'h48, 8'h14, 11'h3e8, 1'b0, 4'h3, 6'h0e, 4'h1},
    '{8'h49, 8'h20, 11'h3e8, 1'b0, 4'h3, 6'h0e, 4'h2},
    '{8'h00, 8'h14, 11'h5dc, 1'b0, 4'h3, 6'h0e, 4'h1},
    '{8'h00, 8'h14, 11'h546, 1'b0, 4'h3, 6'h0e, 4'h1},
    '{8'h00, 8'h14, 11'h2a3, 1'b0, 4'h1, 6'h0e, 4'h1},
    '{8'h40, 8'h14, 11'h2a3, 1'b0, 4'h5, 6'h17, 4'h2},
    '{8'h40, 8'h14, 11'h152, 1'b0, 4'h5, 6'h17, 4'h2},
    '{8'h00, 8'h14, 11'h5dd, 1'b1, 4'h0, 6'h00, 4'h0},
    '{8'h40, 8'h14, 11'h151, 1'b1, 4'h0, 6'h00, 4'h0},
    '{8'h00, 8'h10, 11'h3e8, 1'b1, 4'h0, 6'h00, 4'h0},
    '{8'h49, 8'h1e, 11'h3e8, 1'b1, 4'h0, 6'h00, 4'h0},
    '{8'h49, 8'h24, 11'h3e8, 1'b1, 4'h0, 6'h00, 4'h0},
    '{8'h02, 8'h20, 11'h3e8, 1'b1, 4'h0, 6'h00, 4'h0}
  };
  jtl_link_if link ();
  jtl_tx_dev #(.LOCK_CNT(8)) i_jtl_tx_dev (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .link          (link.dev),
    .fout_mhz_in   (fout),
    .samp_valid_in (sv),
    .samp0_in      (s0),
    .samp1_in      (s1),
    .locked_out    (locked),
    .latency_out   (lat_tot)
  );
  jtl_rx_host i_jtl_rx_host (
    .mclk_in          (mclk_in),
    .rst_in           (rst_in),
    .link             (link.host),
    .start_in         (start),
    .qcfg_in          (qcfg),
    .mf_frames_in     (mf),
    .fout_mhz_in      (fout),
    .busy_out         (busy),
    .ready_out        (ready),
    .cfg_err_out      (cfg_err),
    .samp_valid_out   (hsv),
    .samp0_out        (h0),
    .samp1_out        (h1),
    .lmfc_out         (hlmfc),
    .lat_in2lmfc_out  (lat_a),
    .lat_lmfc2out_out (lat_b)
  );
  jtl_link_assertions i_jtl_link_assertions (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .reg_wr      (link.reg_wr),
    .reg_rd      (link.reg_rd),
    .reg_addr    (link.reg_addr),
    .reg_wdata   (link.reg_wdata),
    .reg_rdata   (link.reg_rdata),
    .reg_rvalid  (link.reg_rvalid),
    .data_valid  (link.data_valid),
    .conv0       (link.conv0),
    .conv1       (link.conv1),
    .frame_start (link.frame_start),
    .lmfc        (link.lmfc)
  );
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (start === 1'b1) begin
      rate_seen <= 8'hee;
    end else if (link.reg_wr === 1'b1 && link.reg_addr === jtl_pkg::REG_LANE_RATE) begin
      rate_seen <= link.reg_wdata;
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask
  // 0: config settled, 1: link data, 2: multiframe pulse
  task automatic wait_sig(input int which, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      tick();
      n++;
      hit = (which == 0) ? (ready | cfg_err) : (which == 1) ? link.data_valid : link.lmfc;
      if (n > 400) begin
        fail_count++;
        $display("wrong value wait %0d expected event seen none", which);
        complete_run();
      end
    end
  endtask
  task automatic run_row(input int i);
    jtl_row_s r;
    int       n;
    r = rows[i];
    qcfg = r.q;
    mf = r.k;
    fout = r.f;
    start = 1'b1;
    tick();
    start = 1'b0;
    check("busy", 32'(!r.err), 32'(busy));
    wait_sig(0, n);
    check("ready", 32'(!r.err), 32'(ready));
    check("cfg error", 32'(r.err), 32'(cfg_err));
    if (!r.err) begin
      check("lane rate", 32'({r.band, 4'h0}), 32'(rate_seen));
      check("lock", 32'h1, 32'(locked));
      check("total", 32'h1f + 32'(r.frm), 32'(lat_tot));
      check("lmfc to out", 32'(r.frm), 32'(lat_b));
      check("in to lmfc", 32'h1f, 32'(lat_a));
      wait_sig(2, n);
      wait_sig(2, n);
      check("lmfc period", 32'(r.k) * 32'(r.s), 32'(n));
      tick();
      check("host lmfc", 32'h1, 32'(hlmfc));
      sv = 1'b1;
      s0 = 8'h5a + 8'(i);
      s1 = 8'ha5 - 8'(i);
      tick();
      sv = 1'b0;
      wait_sig(1, n);
      check("latency", 32'h1f + 32'(r.frm), 32'(n + 1));
      check("conv0", 32'(s0), 32'(link.conv0));
      check("conv1", 32'(r.q[3] ? s1 : 8'h00), 32'(link.conv1));
      tick();
      check("host data", 32'({1'b1, s0}), 32'({hsv, h0}));
      check("host conv1", 32'(r.q[3] ? s1 : 8'h00), 32'(h1));
    end
    $display("row %0d done", i);
  endtask
  initial begin
    rst_in = 1'b1;
    start = 1'b0;
    qcfg = 8'h49;
    mf = 8'h20;
    fout = 11'h3e8;
    sv = 1'b0;
    s0 = 8'h00;
    s1 = 8'ha5;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    check("idle flags", 32'h0, 32'({locked, busy, ready, cfg_err}));
    for (int i = 0; i < NROW; i++) begin
      run_row(i);
    end
    // Restart straight out of the error state
    run_row(7);
    sv = 1'b1;
    tick();
    sv = 1'b0;
    rst_in = 1'b1;
    tick();
    tick();
    rst_in = 1'b0;
    check("reset flags", 32'h0, 32'({locked, busy, ready, cfg_err}));
    check("reset in to lmfc", 32'h1f, 32'(lat_a));
    sv = 1'b1;
    tick();
    sv = 1'b0;
    seen = 1'b0;
    repeat (80) begin
      tick();
      seen = seen | link.data_valid;
    end
    check("unlocked data", 32'h0, 32'(seen));
    run_row(1);
    $display("reset test done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
